/* File: rtl/clock_interlock_defines.vh */
// Summary of operation
// - one control bit turns oscillation stop detection on or off
// - detection enabled forces slow oscillator stop bit to zero
// - while detection enabled, writes of one to slow stop bit are ignored
// - detector needs a settling time after enable before results are valid
// - clock register writes take effect only while write unlock bit is one
`ifndef CLOCK_INTERLOCK_DEFINES_VH
`define CLOCK_INTERLOCK_DEFINES_VH
`define OFS_MAIN_OSC_CTRL    8'h00
`define OFS_SYS_CLOCK_CTRL3  8'h04
`define OFS_PLL_CTRL2        8'h08
`define OFS_SLOW_OSC_CTRL    8'h0C
`define OFS_STOP_DETECT_CTRL 8'h10
`define OFS_WRITE_PROTECT    8'h14
`define OFS_STATUS           8'h18
`define OFS_IRQ_MASK         8'h1C
`define BIT_STOP             0
`define BIT_UNLOCK           0
`define BIT_DETECT_EN        7
`define POS_CKSEL_LO         8
`define POS_CKSEL_HI         10
`define CKSEL_MAIN           3'h2
`define CKSEL_PLL            3'h4
`define RST_MAIN_STOP        1'h1
`define RST_SLOW_STOP        1'h0
`define RST_PLL_HALT         1'h1
`define RST_CKSEL            3'h0
`define SETTLE_TIME_US       10
`define CLK_MHZ              100
`define SETTLE_CYCLES        (`SETTLE_TIME_US * `CLK_MHZ)
`define ST_REFUSED_STOP      0
`define ST_SETTLED           1
`define ST_LOCKED_WRITE      2
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2
`endif

/* File: rtl/clock_source_stop_interlocks.v */
`timescale 1ns/1ps
`include "clock_interlock_defines.vh"
module clock_source_stop_interlocks (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         main_osc_stop,
	output reg         slow_osc_stop,
	output reg         pll_halt,
	output reg  [2:0]  clock_source_select,
	output reg         stop_detect_enable,
	output reg         irq
);
	reg        clock_reg_write_unlock;
	reg [2:0]  status;
	reg [2:0]  mask;
	reg [7:0]  aw_addr;
	reg [31:0] w_data;
	reg [3:0]  w_strb;
	reg        aw_held;
	reg        w_held;
	wire       settled;
	reg        settled_d;
	reg [2:0]  next_status;
	reg        refused;
	reg        locked;
	reg        bad_addr;
	reg        write_ok;
	reg        next_detect_enable;
	reg [2:0]  next_mask;

	// byte 0 only carries control bits here; byte 1 holds the select field
	function lane0;
		input [3:0] strb;
		lane0 = strb[0];
	endfunction

	function is_clock_reg;
		input [7:0] a;
		is_clock_reg = (a == `OFS_MAIN_OSC_CTRL) ||
			(a == `OFS_SYS_CLOCK_CTRL3) || (a == `OFS_PLL_CTRL2) ||
			(a == `OFS_SLOW_OSC_CTRL) || (a == `OFS_STOP_DETECT_CTRL);
	endfunction

	settle_timer u_settle (
		.aclk    (aclk),
		.aresetn (aresetn),
		.enable  (stop_detect_enable),
		.settled (settled)
	);

	// bvalid holds off a second decode until the response is taken
	wire do_write = aw_held && w_held && !s_axi_bvalid;

	always @* begin
		locked   = 1'b0;
		refused  = 1'b0;
		bad_addr = 1'b0;
		if (do_write) begin
			bad_addr = (aw_addr[7:2] > `OFS_IRQ_MASK >> 2) ||
				(aw_addr[1:0] != 2'h0);
			locked = is_clock_reg(aw_addr) && !clock_reg_write_unlock;
			refused = !locked && (aw_addr == `OFS_MAIN_OSC_CTRL) &&
				lane0(w_strb) && w_data[`BIT_STOP] &&
				((clock_source_select == `CKSEL_MAIN) ||
				 (clock_source_select == `CKSEL_PLL) || !pll_halt);
		end
	end

	always @* begin
		next_status = status;
		if (do_write && aw_addr == `OFS_STATUS && lane0(w_strb))
			next_status = status & ~w_data[2:0];
		// set wins over clear
		if (refused)
			next_status[`ST_REFUSED_STOP] = 1'b1;
		if (settled && !settled_d)
			next_status[`ST_SETTLED] = 1'b1;
		if (locked)
			next_status[`ST_LOCKED_WRITE] = 1'b1;
	end

	// enable and mask decoded ahead of their registers so that the force
	// and the interrupt follow a write in the same cycle
	// single enable bit
	always @* begin
		write_ok           = do_write && !locked && !refused &&
			lane0(w_strb);
		next_detect_enable = stop_detect_enable;
		next_mask          = mask;
		if (write_ok && aw_addr == `OFS_STOP_DETECT_CTRL)
			next_detect_enable = w_data[`BIT_DETECT_EN];
		if (write_ok && aw_addr == `OFS_IRQ_MASK)
			next_mask = w_data[2:0];
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			main_osc_stop <= `RST_MAIN_STOP;
			slow_osc_stop <= `RST_SLOW_STOP;
			pll_halt <= `RST_PLL_HALT;
			clock_source_select <= `RST_CKSEL;
			stop_detect_enable <= 1'b0;
			clock_reg_write_unlock <= 1'b0;
			status <= 3'h0;
			mask <= 3'h0;
			settled_d <= 1'b0;
			irq <= 1'b0;
		end else begin
			settled_d <= settled;
			status <= next_status;
			stop_detect_enable <= next_detect_enable;
			mask <= next_mask;
			irq <= |(next_status & next_mask);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
				aw_held <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				w_held <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= bad_addr ? `RESP_SLVERR : `RESP_OKAY;
				if (write_ok) begin
					case (aw_addr)
					`OFS_MAIN_OSC_CTRL:
						main_osc_stop <= w_data[`BIT_STOP];
					`OFS_PLL_CTRL2:
						pll_halt <= w_data[`BIT_STOP];
					// protect register is never locked, else no unlock
					`OFS_WRITE_PROTECT:
						clock_reg_write_unlock <= w_data[`BIT_UNLOCK];
					default: ;
					endcase
				end
				if (!locked && aw_addr == `OFS_SYS_CLOCK_CTRL3 && w_strb[1])
					clock_source_select <=
						w_data[`POS_CKSEL_HI:`POS_CKSEL_LO];
				if (!locked && aw_addr == `OFS_SLOW_OSC_CTRL &&
					lane0(w_strb) && !stop_detect_enable)
					slow_osc_stop <= w_data[`BIT_STOP];
			end
			// acts from the edge that sets enable and on every edge while it stays set; no cycle shows both bits set
			// force slow osc running
			if (next_detect_enable)
				slow_osc_stop <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// read channel; unmapped reads answer slverr with zero data
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			case (s_axi_araddr)
			`OFS_MAIN_OSC_CTRL: s_axi_rdata[0] <= main_osc_stop;
			`OFS_SYS_CLOCK_CTRL3:
				s_axi_rdata[`POS_CKSEL_HI:`POS_CKSEL_LO] <=
					clock_source_select;
			`OFS_PLL_CTRL2: s_axi_rdata[0] <= pll_halt;
			`OFS_SLOW_OSC_CTRL: s_axi_rdata[0] <= slow_osc_stop;
			`OFS_STOP_DETECT_CTRL:
				s_axi_rdata[`BIT_DETECT_EN] <= stop_detect_enable;
			`OFS_WRITE_PROTECT: s_axi_rdata[0] <= clock_reg_write_unlock;
			`OFS_STATUS: s_axi_rdata[2:0] <= status;
			`OFS_IRQ_MASK: s_axi_rdata[2:0] <= mask;
			default: s_axi_rresp <= `RESP_SLVERR;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule // clock_source_stop_interlocks

/* File: rtl/settle_timer.v */
`timescale 1ns/1ps
`include "clock_interlock_defines.vh"
module settle_timer (
	input  wire aclk,
	input  wire aresetn,
	input  wire enable,
	output reg  settled
);
	reg [15:0] count;
	always @(posedge aclk) begin
		if (!aresetn || !enable) begin
			count   <= 16'h0000;
			settled <= 1'b0;
		end else if (count == `SETTLE_CYCLES - 1) begin
			settled <= 1'b1;
		end else begin
			count <= count + 16'h0001;
		end
	end
endmodule // settle_timer

/* File: testbench/interlock_monitor.sv */
`timescale 1ns/1ps
module interlock_monitor (
	input wire		aclk,
	input wire		aresetn,
	input wire		main_osc_stop,
	input wire		slow_osc_stop,
	input wire		pll_halt,
	input wire [2:0]	clock_source_select,
	input wire		stop_detect_enable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_SLOW_FORCED: assert property (
		stop_detect_enable |-> !slow_osc_stop)
		else $error("slow oscillator stopped while detection on");
	AST_SLOW_NO_STOP: assert property (
		$rose(slow_osc_stop) |-> !$past(stop_detect_enable))
		else $error("slow oscillator stop accepted during detection");
	AST_MAIN_SEL: assert property (
		$rose(main_osc_stop) |-> $past(clock_source_select) != 3'h2)
		else $error("main oscillator stopped while it clocks the system");
	AST_MAIN_PLLSEL: assert property (
		$rose(main_osc_stop) |-> $past(clock_source_select) != 3'h4)
		else $error("main oscillator stopped while pll clocks the system");
	AST_MAIN_PLLRUN: assert property (
		$rose(main_osc_stop) |-> $past(pll_halt))
		else $error("main oscillator stopped while pll runs");
	cover property ($rose(stop_detect_enable));
	cover property ($rose(main_osc_stop));
	cover property ($fell(main_osc_stop));
endmodule // interlock_monitor

bind clock_source_stop_interlocks interlock_monitor mon_u (.aclk, .aresetn,
	.main_osc_stop, .slow_osc_stop, .pll_halt, .clock_source_select,
	.stop_detect_enable);

/* File: testbench/tb_clock_source_stop_interlocks.sv */
`timescale 1ns/1ps
`define CK(a,b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_clock_source_stop_interlocks;
	reg		aclk = 0, aresetn = 0;
	reg [7:0]	s_axi_awaddr = 0, s_axi_araddr = 0;
	reg [31:0]	s_axi_wdata = 0;
	reg		s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	wire		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire		s_axi_rvalid, irq, main_osc_stop, slow_osc_stop, pll_halt;
	wire		stop_detect_enable;
	wire [1:0]	s_axi_bresp, s_axi_rresp;
	wire [31:0]	s_axi_rdata;
	wire [2:0]	clock_source_select;
	integer		miscompares = 0, n_checks = 0, cyc = 0, i;
	reg		m_mo = 1, m_so = 0, m_ph = 1, m_de = 0, m_ul = 0;
	reg [2:0]	m_cs = 0, m_st = 0, m_mk = 0;
	reg [1:0]	r;
	reg [31:0]	d;
	// responses always accepted at once, legal since ready may stay high
	clock_source_stop_interlocks dut_u (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .main_osc_stop,
		.slow_osc_stop, .pll_halt, .clock_source_select,
		.stop_detect_enable, .irq);
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) tally_and_finish(1);
	end
	task tally_and_finish(input integer to);
		if (to) miscompares++;
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task w(input [7:0] a, input [31:0] v);
		reg ad, wd, bad;
		reg [7:0] got, want;
		ad = 0;
		wd = 0;
		bad = (a > 8'h1C) || (a[1:0] != 2'h0);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				ad = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		`CK(s_axi_bresp, bad ? 2'h2 : 2'h0)
		if (bad) ;
		else if (a == 8'h14) m_ul = v[0];
		else if (a == 8'h18) m_st = m_st & ~v[2:0];
		else if (a == 8'h1C) m_mk = v[2:0];
		else if (!m_ul) m_st[2] = 1;
		else case (a)
			8'h00: if (v[0] && (m_cs == 2 || m_cs == 4 || !m_ph)) m_st[0] = 1;
				else m_mo = v[0];
			8'h04: m_cs = v[10:8];
			8'h08: m_ph = v[0];
			8'h0C: if (!m_de) m_so = v[0];
			8'h10: begin
				m_de = v[7];
				if (v[7]) m_so = 0;
			end
		endcase
		repeat (2) @(posedge aclk);
		got = {main_osc_stop, slow_osc_stop, pll_halt, clock_source_select,
			stop_detect_enable, irq};
		want = {m_mo, m_so, m_ph, m_cs, m_de, |(m_st & m_mk)};
		`CK(got, want)
	endtask
	task rd(input [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		r = s_axi_rresp;
		d = s_axi_rdata;
	endtask
	function [31:0] model_word(input [7:0] a);
		case (a)
			8'h00: model_word = {31'h0, m_mo};
			8'h04: model_word = {21'h0, m_cs, 8'h00};
			8'h08: model_word = {31'h0, m_ph};
			8'h0C: model_word = {31'h0, m_so};
			8'h10: model_word = {24'h0, m_de, 7'h00};
			8'h14: model_word = {31'h0, m_ul};
			8'h18: model_word = {29'h0, m_st};
			default: model_word = {29'h0, m_mk};
		endcase
	endfunction
	task check_regs;
		integer k;
		for (k = 0; k < 8; k++) begin
			rd({k[5:0], 2'h0});
			`CK({r, d}, {2'h0, model_word({k[5:0], 2'h0})})
		end
	endtask
	initial begin
		d = $urandom(32'h84814AD6);
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		w(8'h00, 0);
		w(8'h1C, 1);
		w(8'h14, 1);
		for (i = 0; i < 16; i++) begin
			w(8'h04, {21'h0, i[2:0], 8'h00});
			w(8'h08, $urandom % 2);
			w(8'h00, 0);
			w(8'h00, 1);
		end
		w(8'h18, 7);
		w(8'h0C, 1);
		w(8'h10, 32'h80);
		w(8'h0C, 1);
		rd(8'h18);
		`CK(d[2:0], m_st)
		// detector result only trusted after the settle window
		repeat (980) @(posedge aclk);
		rd(8'h18);
		`CK(d[2:0], m_st)
		repeat (20) @(posedge aclk);
		m_st[1] = 1;
		rd(8'h18);
		`CK(d[2:0], m_st)
		w(8'h14, 0);
		w(8'h10, 0);
		w(8'h24, 1);
		w(8'h0D, 1);
		rd(8'h20);
		`CK({r, d}, {2'h2, 32'h0})
		rd(8'h0E);
		`CK({r, d}, {2'h2, 32'h0})
		check_regs;
		// mid-run reset must bring every register back to its reset value; the unlock bit is rewritten to one before the check
		aresetn <= 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		{m_mo, m_so, m_ph, m_de, m_ul} = 5'h14;
		{m_cs, m_st, m_mk} = 9'h000;
		w(8'h14, 1);
		check_regs;
		tally_and_finish(0);
	end
endmodule // tb_clock_source_stop_interlocks
